// ---- shared/fra_pkg.sv ----
`default_nettype none
package fra_pkg;
   // ----------------------------------------
   // bus map
   // ----------------------------------------
   localparam int           ADDR_W      = 12;
   localparam logic [11:0]  OFF_INSTR   = 12'h000;
   localparam logic [11:0]  OFF_ACC     = 12'h004;
   localparam logic [11:0]  OFF_STATUS  = 12'h008;
   localparam logic [11:0]  OFF_COUNT   = 12'h00c;
   localparam logic [2:0]   FILE_WIN_HI = 3'h1;
   localparam int           FILE_SEL_LSB = 9;
   localparam logic [1:0]   RESP_OKAY   = 2'h0;
   localparam logic [1:0]   RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0]   ACC_RESET   = 8'h00;
   localparam logic [7:0]   FILE_RESET  = 8'h00;
   // ----------------------------------------
   // instruction encodings
   // ----------------------------------------
   localparam logic [5:0]   OP_ADD      = 6'h07;
   localparam logic [5:0]   OP_AND      = 6'h05;
   localparam logic [3:0]   OP_CLR      = 4'h4;
   localparam logic [3:0]   OP_SET      = 4'h5;
   typedef struct packed {
      logic [5:0] op;
      logic       dest;
      logic [6:0] faddr;
   } fra_byte_instr_type;
   typedef struct packed {
      logic [3:0] op;
      logic [2:0] bitpos;
      logic [6:0] faddr;
   } fra_bit_instr_type;
   typedef struct packed {
      logic unsup;
      logic z;
      logic digit_carry_flag;
      logic c;
   } fra_flags_type;
   localparam fra_flags_type FLAGS_RESET = 4'h0;
endpackage
`default_nettype wire

// ---- core/fra_core.sv ----
// Contract
// - add sums accumulator and file register
// - dest zero writes accumulator only
// - dest one writes file register only
// - and forms bitwise accumulator and file
// - byte ops: 7-bit address, dest bit
// - bit clear zeroes selected bit only
// - bit set ones selected bit only
// - bit ops: 3-bit position, 7-bit address
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module fra_core #(
   parameter int FILE_DEPTH = 128
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready
);
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]          file_q [FILE_DEPTH];
   logic [7:0]          acc_q;
   fra_pkg::fra_flags_type flags_q;
   fra_pkg::fra_flags_type flags_d;
   logic [31:0]         count_q;
   logic [11:0]         awaddr_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                aw_full_q;
   logic                w_full_q;

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   wire aw_hs  = awvalid & awready;
   wire w_hs   = wvalid & wready;
   wire b_hs   = bvalid & bready;
   wire commit = aw_full_q & w_full_q & ~bvalid;
   wire wr_instr  = awaddr_q == fra_pkg::OFF_INSTR;
   wire wr_acc    = awaddr_q == fra_pkg::OFF_ACC;
   wire wr_status = awaddr_q == fra_pkg::OFF_STATUS;
   wire wr_count  = awaddr_q == fra_pkg::OFF_COUNT;
   wire wr_file   = awaddr_q[11:fra_pkg::FILE_SEL_LSB] == fra_pkg::FILE_WIN_HI;
   wire wr_known  = wr_instr | wr_acc | wr_status | wr_count | wr_file;
   wire [31:0] wr_word = merge(32'h0, wdata_q, wstrb_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= fra_pkg::RESP_OKAY;
         awaddr_q  <= 12'h000;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
      end else begin
         if (aw_hs) begin
            awaddr_q  <= awaddr;
            aw_full_q <= 1'b1;
            awready   <= 1'b0;
         end
         if (w_hs) begin
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
            w_full_q <= 1'b1;
            wready   <= 1'b0;
         end
         if (commit) begin
            bvalid <= 1'b1;
            bresp  <= wr_known ? fra_pkg::RESP_OKAY : fra_pkg::RESP_SLVERR;
         end
         if (b_hs) begin
            bvalid    <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // instruction execution
   // ----------------------------------------
   // an instruction runs in the cycle its word is committed
   wire exec = commit & wr_instr;
   wire fra_pkg::fra_byte_instr_type bi = fra_pkg::fra_byte_instr_type'(wr_word[13:0]);
   wire fra_pkg::fra_bit_instr_type  ti = fra_pkg::fra_bit_instr_type'(wr_word[13:0]);
   wire is_add  = exec & (bi.op == fra_pkg::OP_ADD);
   wire is_and  = exec & (bi.op == fra_pkg::OP_AND);
   wire is_clr  = exec & (ti.op == fra_pkg::OP_CLR);
   wire is_set  = exec & (ti.op == fra_pkg::OP_SET);
   wire byte_op = is_add | is_and;
   wire unsup   = exec & ~(byte_op | is_clr | is_set);
   wire [6:0] faddr = bi.faddr;
   wire [7:0] fdata = file_q[faddr];
   wire [8:0] sum9  = {1'b0, acc_q} + {1'b0, fdata};
   wire [4:0] nib5  = {1'b0, acc_q[3:0]} + {1'b0, fdata[3:0]};
   wire [7:0] and_res = acc_q & fdata;
   wire [7:0] alu_res = is_add ? sum9[7:0] : and_res;
   wire [7:0] bmask   = 8'h01 << ti.bitpos;
   wire [7:0] bit_res = is_set ? (fdata | bmask) : (fdata & ~bmask);
   wire acc_we_x  = byte_op & ~bi.dest;
   wire file_we_x = (byte_op & bi.dest) | is_clr | is_set;
   wire sw_acc    = commit & wr_acc;
   wire sw_file   = commit & wr_file;
   wire file_we   = file_we_x | sw_file;
   wire [6:0] file_idx = sw_file ? awaddr_q[8:2] : faddr;
   wire [7:0] file_wd  = sw_file ? wr_word[7:0] : (byte_op ? alu_res : bit_res);
   wire [31:0] acc_word = merge({24'h0, acc_q}, wdata_q, wstrb_q);
   wire [7:0] acc_d    = sw_acc ? acc_word[7:0] : alu_res;

   always_comb begin
      flags_d = flags_q;
      if (commit & wr_status) begin
         flags_d = fra_pkg::fra_flags_type'(wr_word[3:0]);
      end else if (is_add) begin
         flags_d.c  = sum9[8];
         flags_d.digit_carry_flag = nib5[4];
         flags_d.z  = sum9[7:0] == 8'h00;
      end else if (is_and) begin
         flags_d.z  = and_res == 8'h00;
      end else if (unsup) begin
         flags_d.unsup = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_q   <= fra_pkg::ACC_RESET;
         flags_q <= fra_pkg::FLAGS_RESET;
         count_q <= 32'h0;
      end else begin
         if (acc_we_x | sw_acc) begin
            acc_q <= acc_d;
         end
         flags_q <= flags_d;
         if (exec & ~unsup) begin
            count_q <= count_q + 32'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_q[i] <= fra_pkg::FILE_RESET;
         end
      end else if (file_we) begin
         file_q[file_idx] <= file_wd;
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   wire ar_hs = arvalid & arready;
   wire r_hs  = rvalid & rready;
   wire rd_acc    = araddr == fra_pkg::OFF_ACC;
   wire rd_status = araddr == fra_pkg::OFF_STATUS;
   wire rd_count  = araddr == fra_pkg::OFF_COUNT;
   wire rd_instr  = araddr == fra_pkg::OFF_INSTR;
   wire rd_file   = araddr[11:fra_pkg::FILE_SEL_LSB] == fra_pkg::FILE_WIN_HI;
   wire [31:0] rd_data_d = rd_acc ? {24'h0, acc_q} :
                           rd_status ? {28'h0, flags_q} :
                           rd_count ? count_q :
                           rd_file ? {24'h0, file_q[araddr[8:2]]} : 32'h0;
   wire [1:0] rd_resp_d = (rd_acc | rd_status | rd_count | rd_instr | rd_file) ?
                          fra_pkg::RESP_OKAY : fra_pkg::RESP_SLVERR;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= fra_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_data_d;
         rresp   <= rd_resp_d;
      end else if (r_hs) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_ADD_TO_ACC: assert property (@(posedge aclk) disable iff (!aresetn)
      is_add & ~bi.dest |=> acc_q == $past(sum9[7:0])) else $error("add result wrong in accumulator");
   AST_DEST0_FILE_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
      byte_op & ~bi.dest |=> file_q[$past(faddr)] == $past(fdata)) else $error("file changed with dest 0");
   AST_DEST1_TO_FILE: assert property (@(posedge aclk) disable iff (!aresetn)
      byte_op & bi.dest |=> file_q[$past(faddr)] == $past(alu_res) && $stable(acc_q))
      else $error("dest 1 result misrouted");
   AST_AND_TO_ACC: assert property (@(posedge aclk) disable iff (!aresetn)
      is_and & ~bi.dest |=> acc_q == ($past(acc_q) & $past(fdata))) else $error("and result wrong");
   AST_BIT_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      is_clr |=> file_q[$past(faddr)] == ($past(fdata) & ~(8'h01 << $past(ti.bitpos))))
      else $error("bit clear wrong");
   AST_BIT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      is_set |=> file_q[$past(faddr)] == ($past(fdata) | (8'h01 << $past(ti.bitpos))))
      else $error("bit set wrong");
   AST_BIT_FLAGS_KEPT: assert property (@(posedge aclk) disable iff (!aresetn)
      is_clr | is_set |=> $stable(flags_q) && $stable(acc_q)) else $error("bit op touched flags");
   AST_AND_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
      is_and |=> flags_q.c == $past(flags_q.c) && flags_q.digit_carry_flag == $past(flags_q.digit_carry_flag)
                 && flags_q.z == ($past(and_res) == 8'h00)) else $error("and flags wrong");
   AST_ADD_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
      is_add |=> flags_q.c == $past(sum9[8]) && flags_q.digit_carry_flag == $past(nib5[4])
                 && flags_q.z == ($past(sum9[7:0]) == 8'h00)) else $error("add flags wrong");
   AST_UNKNOWN_OP: assert property (@(posedge aclk) disable iff (!aresetn)
      unsup |=> flags_q.unsup && $stable(acc_q) && $stable(count_q)) else $error("unknown op not ignored");
   AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_hs & w_hs |=> ##[0:1] bvalid) else $error("write answer late");
endmodule
`default_nettype wire

// ---- tb/fra_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// axi4-lite master standing for the decoder side
// ----------------------------------------
module fra_host (
   input  wire logic        aclk,
   output var  logic [11:0] awaddr,
   output var  logic        awvalid,
   input  wire logic        awready,
   output var  logic [31:0] wdata,
   output var  logic [3:0]  wstrb,
   output var  logic        wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output var  logic        bready,
   output var  logic [11:0] araddr,
   output var  logic        arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output var  logic        rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
   end
   // released payloads are inverted so a stale value never passes
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && awready === 1'b1) begin
            awvalid <= 1'b0;
            awaddr  <= ~a;
            pa = 1'b0;
         end
         if (pw && wready === 1'b1) begin
            wvalid <= 1'b0;
            wdata  <= ~d;
            pw = 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr  <= ~a;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tb/fra_core_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module fra_core_tb;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rd_r;
   int          err_total, checked, n_exec;
   always #5 aclk = ~aclk;
   fra_core #(.FILE_DEPTH(128)) fra_core_i (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready)
   );
   fra_host fra_host_i (
      .aclk    (aclk),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      fra_host_i.rd(a, rd_d, rd_r);
      chk(rd_d, exp);
   endtask
   task automatic wf(input logic [6:0] f, input logic [7:0] v);
      fra_host_i.wr({3'h1, f, 2'h0}, {24'h0, v}, rd_r);
   endtask
   task automatic rf(input logic [6:0] f, input logic [7:0] v);
      rchk({3'h1, f, 2'h0}, {24'h0, v});
   endtask
   task automatic wreg(input logic [11:0] a, input logic [7:0] v);
      fra_host_i.wr(a, {24'h0, v}, rd_r);
   endtask
   task automatic ex(input logic [13:0] ins);
      n_exec++;
      fra_host_i.wr(fra_pkg::OFF_INSTR, {18'h0, ins}, rd_r);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_add;
      wreg(fra_pkg::OFF_ACC, 8'h17);
      wf(7'h05, 8'hc2);
      ex({6'b000111, 1'b0, 7'h05});
      rchk(fra_pkg::OFF_ACC, 32'hd9);
      rf(7'h05, 8'hc2);
      rchk(fra_pkg::OFF_STATUS, 32'h0);
      // carry out of both nibbles and a zero result at the top address
      wreg(fra_pkg::OFF_ACC, 8'h38);
      wf(7'h7f, 8'hc8);
      ex({6'b000111, 1'b1, 7'h7f});
      rf(7'h7f, 8'h00);
      rchk(fra_pkg::OFF_ACC, 32'h38);
      rchk(fra_pkg::OFF_STATUS, 32'h7);
      $display("test add done");
   endtask
   task automatic t_and;
      wreg(fra_pkg::OFF_STATUS, 8'h03);
      wreg(fra_pkg::OFF_ACC, 8'h17);
      wf(7'h02, 8'hc2);
      ex({6'b000101, 1'b1, 7'h02});
      rf(7'h02, 8'h02);
      rchk(fra_pkg::OFF_ACC, 32'h17);
      rchk(fra_pkg::OFF_STATUS, 32'h3);
      wf(7'h00, 8'h08);
      ex({6'b000101, 1'b0, 7'h00});
      rchk(fra_pkg::OFF_ACC, 32'h00);
      rf(7'h00, 8'h08);
      rchk(fra_pkg::OFF_STATUS, 32'h7);
      $display("test and done");
   endtask
   task automatic t_bits;
      wreg(fra_pkg::OFF_STATUS, 8'h05);
      for (int i = 0; i < 8; i++) begin
         wf(7'h40, 8'hff);
         ex({4'b0100, 3'(i), 7'h40});
         rf(7'h40, 8'hff ^ (8'h01 << i));
         wf(7'h40, 8'h00);
         ex({4'b0101, 3'(i), 7'h40});
         rf(7'h40, 8'h01 << i);
      end
      rchk(fra_pkg::OFF_STATUS, 32'h5);
      $display("test bits done");
   endtask
   task automatic t_bad;
      fra_host_i.wr(fra_pkg::OFF_INSTR, 32'h3fff, rd_r);
      chk({30'h0, rd_r}, {30'h0, fra_pkg::RESP_OKAY});
      rchk(fra_pkg::OFF_STATUS, 32'hd);
      rchk(fra_pkg::OFF_COUNT, n_exec);
      // unmapped write must answer an error and leave the accumulator alone
      fra_host_i.wr(12'h010, 32'h55, rd_r);
      chk({30'h0, rd_r}, {30'h0, fra_pkg::RESP_SLVERR});
      rchk(fra_pkg::OFF_ACC, 32'h00);
      fra_host_i.rd(fra_pkg::OFF_INSTR, rd_d, rd_r);
      chk(rd_d, 32'h0);
      chk({30'h0, rd_r}, {30'h0, fra_pkg::RESP_OKAY});
      fra_host_i.rd(12'h010, rd_d, rd_r);
      chk(rd_d, 32'h0);
      chk({30'h0, rd_r}, {30'h0, fra_pkg::RESP_SLVERR});
      $display("test bad done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // run
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      err_total = 0;
      checked = 0;
      n_exec = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(fra_pkg::OFF_STATUS, 32'h0);
      rf(7'h7f, 8'h00);
      t_add;
      t_and;
      t_bits;
      t_bad;
      finish_test;
   end
   // whole run is about three hundred cycles; the 10000-cycle limit is some thirty times that and means a hang
   initial begin
      #100000;
      err_total++;
      finish_test;
   end
endmodule
`default_nettype wire
